//--- pdld_cfg.svh
`ifndef PDLD_CFG_SVH
`define PDLD_CFG_SVH

// ==========================================================
// Register offsets
`define PDLD_OFS_PUMP      10'h010
`define PDLD_OFS_RDIV_LO   10'h011
`define PDLD_OFS_RDIV_HI   10'h012
`define PDLD_OFS_SWALLOW   10'h013
`define PDLD_OFS_MAIN_LO   10'h014
`define PDLD_OFS_MAIN_HI   10'h015
`define PDLD_OFS_PRES_RST  10'h016
`define PDLD_OFS_STAT_SEL  10'h017
`define PDLD_OFS_LOCK_CAL  10'h018
`define PDLD_OFS_SYNC_RST  10'h019
`define PDLD_OFS_LDPIN_FN  10'h01a
`define PDLD_OFS_MON_SEL   10'h01b
`define PDLD_OFS_LOCK_CMP  10'h01d
`define PDLD_OFS_READBACK  10'h01f

// ==========================================================
// Field positions
`define PDLD_CPMODE_LSB    2
`define PDLD_CPCUR_LSB     4
`define PDLD_RDIV_HI_W     6
`define PDLD_SWALLOW_W     6
`define PDLD_MAIN_HI_W     5
`define PDLD_PRES_LSB      0
`define PDLD_BRST_BIT      4
`define PDLD_SHARED_BIT    5
`define PDLD_RRST_BIT      6
`define PDLD_STATSEL_LSB   2
`define PDLD_CALEN_BIT     0
`define PDLD_CALDIV_LSB    1
`define PDLD_DLDOFF_BIT    3
`define PDLD_LOCKTHR_LSB   5
`define PDLD_SYNCEN_LSB    6
`define PDLD_MONSEL_W      5
`define PDLD_CMPEN_BIT     3
`define PDLD_RB_DLD_BIT    0
`define PDLD_RB_CAL_BIT    6

// ==========================================================
// Pin function codes
`define PDLD_LDFN_DLD      6'h00
`define PDLD_LDFN_ALD_LOW  6'h01
`define PDLD_LDFN_ALD_HIGH 6'h02
`define PDLD_LDFN_CLD      6'h04
`define PDLD_SEL_DLD       6'h01
`define PDLD_SEL_CMP       6'h02

// ==========================================================
// Lock counter thresholds, selected by two bits
`define PDLD_THR0          8'h05
`define PDLD_THR1          8'h10
`define PDLD_THR2          8'h40
`define PDLD_THR3          8'hff

// ==========================================================
// Timing
`define PDLD_CLK_PERIOD_PS 25000
`define PDLD_LOCK_WIN_PS   3500
`define PDLD_LOCK_WIN_CYC  (((`PDLD_LOCK_WIN_PS / `PDLD_CLK_PERIOD_PS) > 0) ? \
                            (`PDLD_LOCK_WIN_PS / `PDLD_CLK_PERIOD_PS) : 1)
`define PDLD_CAL_CLOCKS    4400
`define PDLD_REF_MAX       16383

`endif

//--- pdld_pkg.sv
package pdld_pkg;

  typedef enum logic [1:0] {
    PDLD_CP_NORMAL = 2'b00,
    PDLD_CP_HIGHZ  = 2'b01,
    PDLD_CP_UP     = 2'b10,
    PDLD_CP_DOWN   = 2'b11
  } pdld_cp_mode_t;

  typedef enum logic [1:0] {
    PDLD_CAL_IDLE = 2'b00,
    PDLD_CAL_RUN  = 2'b01,
    PDLD_CAL_DONE = 2'b10
  } pdld_cal_state_t;

  typedef struct packed {
    logic [7:0] pumpLoop;
    logic [7:0] refDivLo;
    logic [7:0] refDivHi;
    logic [7:0] swallowCnt;
    logic [7:0] mainCntLo;
    logic [7:0] mainCntHi;
    logic [7:0] presReset;
    logic [7:0] statusSel;
    logic [7:0] lockCal;
    logic [7:0] syncRst;
    logic [7:0] lockPinFn;
    logic [7:0] monitorSel;
    logic [7:0] lockCmp;
  } pdld_regs_t;

  typedef struct packed {
    logic [1:0] refS;
    logic       refPrev;
    logic [1:0] fbS;
    logic       fbPrev;
    logic [1:0] syncS;
    logic       syncPrev;
    logic [1:0] resetS;
    logic [1:0] cmpS;
  } pdld_sync_t;

  typedef struct packed {
    logic       up;
    logic       down;
    logic       highZ;
    logic [2:0] currentSel;
  } pdld_pump_t;

  typedef struct packed {
    pdld_regs_t      regs;
    pdld_sync_t      sync;
    logic [13:0]     rCount;
    logic [6:0]      pCount;
    logic [5:0]      aRemain;
    logic [12:0]     bCount;
    logic            pfdUp;
    logic            pfdDown;
    logic [7:0]      phaseErr;
    logic [7:0]      lockCount;
    logic            digitalLockFlag;
    pdld_cal_state_t calState;
    logic            calArmPrev;
    logic [3:0]      calDiv;
    logic [12:0]     calCount;
    pdld_pump_t      pump;
    logic            ldOut;
    logic            ldOeN;
    logic            ldSource;
    logic            ldDischarge;
    logic            statusPin;
    logic            watchPin;
    logic            outputsHold;
    logic [7:0]      rdData;
  } pdld_state_t;

endpackage

//--- pdld_pll_ctrl.sv
`include "pdld_cfg.svh"

// Functional notes
// R1: Fourteen-bit reference divider; zero divides by one
// R2: Reference counter reset by reset sources, sync release
// R3: Phase comparator gives up/down from divider outputs
// R4: Pump mode: normal, high-Z, force up, down
// R5: Pump current field selects eight equal steps
// R6: Software calibrates after power-up or reset
// R7: Calibration holds distribution outputs static
// R8: Calibration finishes within 4400 calibration clocks
// R9: Calibration clock is reference output divided 2..16
// R10: Completion readback bit set when calibration ends
// R11: A zero gives fixed divide, ratio P*B
// R12: Dual modulus: P+1 for A, total P*B+A
// R13: Software keeps prescaler output within limit
// R14: B range 3..8191, one bypasses counter
// R15: A six bits; B from low, high registers
// R16: Software keeps A not above B
// R17: Sync pin and bits reset P, A, B
// R18: Lock after threshold of consecutive good comparisons
// R19: Single bad comparison declares unlock
// R20: Digital lock routable to lock, status, watch pins
// R21: Current-source lock mode, comparator routable to pins
// R22: Lock pin codes select open-drain analog lock
module pdld_pll_ctrl
  import pdld_pkg::*;
#(
  parameter int CAL_CLOCKS = `PDLD_CAL_CLOCKS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [9:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       referenceInput,
  input  wire logic       feedbackInput,
  input  wire logic       syncN,
  input  wire logic       resetN,
  input  wire logic       lockComparatorIn,
  output logic            chargePumpUp,
  output logic            chargePumpDown,
  output logic            chargePumpHighZ,
  output logic      [2:0] chargePumpCurrent,
  output logic            lockIndicatorPinOut,
  output logic            lockIndicatorPinOeN,
  output logic            chargedLockIndication,
  output logic            lockPinDischarge,
  output logic            statusPin,
  output logic            referenceWatchPin,
  output logic            outputsHold
);

  localparam logic [12:0] CAL_LAST = 13'(CAL_CLOCKS - 1);
  localparam logic [7:0]  WIN_CYC  = 8'(`PDLD_LOCK_WIN_CYC);

  // ========================================================
  // Helpers
  function automatic logic [6:0] presModulus(input logic [2:0] code);
    logic [6:0] m;
    m = 7'h20;
    unique case (code)
      3'h0:    m = 7'h01;
      3'h1:    m = 7'h02;
      3'h2:    m = 7'h04;
      3'h3:    m = 7'h08;
      3'h4:    m = 7'h10;
      default: m = 7'h20;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] lockThreshold(input logic [1:0] sel);
    logic [7:0] t;
    t = `PDLD_THR0;
    unique case (sel)
      2'b00: t = `PDLD_THR0;
      2'b01: t = `PDLD_THR1;
      2'b10: t = `PDLD_THR2;
      2'b11: t = `PDLD_THR3;
    endcase
    return t;
  endfunction

  pdld_state_t stateReg;
  pdld_state_t stateNext;

  // ========================================================
  // Next state
  always_comb begin
    logic [13:0]   refDiv;
    logic [12:0]   bVal;
    logic [5:0]    aVal;
    logic [6:0]    modulus;
    logic [4:0]    calDivisor;
    logic          refEdge;
    logic          fbEdge;
    logic          syncRise;
    logic          rReset;
    logic          abReset;
    logic          refPulse;
    logic          presPulse;
    logic          fbPulse;
    logic          upNow;
    logic          downNow;
    logic          compare;
    logic          goodCompare;
    logic          dldOff;
    logic          cmpOut;
    logic          aldRaw;
    logic [5:0]    ldFn;
    logic [5:0]    statSel;
    logic [5:0]    monSel;
    pdld_cp_mode_t cpMode;

    stateNext = stateReg;

    // Two-stage synchronisers on every pin; edges look at stage two only
    stateNext.sync.refS     = {stateReg.sync.refS[0], referenceInput};
    stateNext.sync.refPrev  = stateReg.sync.refS[1];
    stateNext.sync.fbS      = {stateReg.sync.fbS[0], feedbackInput};
    stateNext.sync.fbPrev   = stateReg.sync.fbS[1];
    stateNext.sync.syncS    = {stateReg.sync.syncS[0], syncN};
    stateNext.sync.syncPrev = stateReg.sync.syncS[1];
    stateNext.sync.resetS   = {stateReg.sync.resetS[0], resetN};
    stateNext.sync.cmpS     = {stateReg.sync.cmpS[0], lockComparatorIn};
    refEdge  = stateReg.sync.refS[1] & ~stateReg.sync.refPrev;
    fbEdge   = stateReg.sync.fbS[1] & ~stateReg.sync.fbPrev;
    syncRise = stateReg.sync.syncS[1] & ~stateReg.sync.syncPrev;

    refDiv = {stateReg.regs.refDivHi[`PDLD_RDIV_HI_W-1:0], stateReg.regs.refDivLo};
    aVal   = stateReg.regs.swallowCnt[`PDLD_SWALLOW_W-1:0]; // R15
    bVal   = {stateReg.regs.mainCntHi[`PDLD_MAIN_HI_W-1:0], stateReg.regs.mainCntLo}; // R15
    ldFn   = stateReg.regs.lockPinFn[5:0];
    statSel = stateReg.regs.statusSel[7:`PDLD_STATSEL_LSB];
    monSel  = {1'b0, stateReg.regs.monitorSel[`PDLD_MONSEL_W-1:0]};
    dldOff  = stateReg.regs.lockCal[`PDLD_DLDOFF_BIT];
    cpMode  = pdld_cp_mode_t'(stateReg.regs.pumpLoop[`PDLD_CPMODE_LSB +: 2]);

    // ========================================================
    // Reference divider
    rReset = ~stateReg.sync.resetS[1] | stateReg.regs.presReset[`PDLD_RRST_BIT]
           | stateReg.regs.presReset[`PDLD_SHARED_BIT] | syncRise; // R2
    refPulse = 1'b0;
    if (rReset) begin
      stateNext.rCount = '0; // R2
    end else if (refEdge) begin
      if (stateReg.rCount >= refDiv - 14'h0001 || refDiv == '0) begin
        stateNext.rCount = '0; // R1
        refPulse = 1'b1;
      end else begin
        stateNext.rCount = stateReg.rCount + 14'h0001; // R1
      end
    end

    // ========================================================
    // Feedback divider: prescaler with swallow and main counters
    abReset = stateReg.regs.presReset[`PDLD_BRST_BIT]
            | stateReg.regs.presReset[`PDLD_SHARED_BIT]
            | ((stateReg.regs.syncRst[`PDLD_SYNCEN_LSB +: 2] != 2'b00)
               & ~stateReg.sync.syncS[1]); // R17
    modulus = presModulus(stateReg.regs.presReset[`PDLD_PRES_LSB +: 3]);
    if (stateReg.aRemain != '0 && bVal != 13'h0001) begin
      modulus = modulus + 7'h01; // R12
    end
    presPulse = 1'b0;
    fbPulse   = 1'b0;
    if (abReset) begin
      stateNext.pCount  = '0; // R17
      stateNext.bCount  = '0;
      stateNext.aRemain = aVal;
    end else if (fbEdge) begin
      if (stateReg.pCount >= modulus - 7'h01) begin
        stateNext.pCount = '0;
        presPulse = 1'b1;
      end else begin
        stateNext.pCount = stateReg.pCount + 7'h01;
      end
    end
    if (presPulse) begin
      if (bVal == 13'h0001) begin
        fbPulse = 1'b1; // R14
      end else if (stateReg.bCount >= bVal - 13'h0001) begin
        stateNext.bCount  = '0; // R11
        stateNext.aRemain = aVal;
        fbPulse = 1'b1;
      end else begin
        stateNext.bCount = stateReg.bCount + 13'h0001;
        if (stateReg.aRemain != '0) begin
          stateNext.aRemain = stateReg.aRemain - 6'h01; // R12
        end
      end
    end

    // ========================================================
    // Phase comparator and lock detection
    upNow   = stateReg.pfdUp | refPulse;
    downNow = stateReg.pfdDown | fbPulse;
    compare = upNow & downNow;
    goodCompare = stateReg.phaseErr < WIN_CYC;
    if (compare) begin
      stateNext.pfdUp    = 1'b0; // R3
      stateNext.pfdDown  = 1'b0;
      stateNext.phaseErr = '0;
    end else begin
      stateNext.pfdUp   = upNow; // R3
      stateNext.pfdDown = downNow;
      if ((upNow | downNow) && stateReg.phaseErr != 8'hff) begin
        stateNext.phaseErr = stateReg.phaseErr + 8'h01;
      end
    end
    if (dldOff) begin
      stateNext.lockCount       = '0;
      stateNext.digitalLockFlag = 1'b0;
    end else if (compare) begin
      if (!goodCompare) begin
        stateNext.lockCount       = '0; // R19
        stateNext.digitalLockFlag = 1'b0;
      end else if (stateReg.lockCount >=
                   lockThreshold(stateReg.regs.lockCal[`PDLD_LOCKTHR_LSB +: 2])) begin
        stateNext.digitalLockFlag = 1'b1; // R18
      end else begin
        stateNext.lockCount = stateReg.lockCount + 8'h01; // R18
      end
    end

    // ========================================================
    // Charge pump
    stateNext.pump.currentSel = stateReg.regs.pumpLoop[`PDLD_CPCUR_LSB +: 3]; // R5
    unique case (cpMode) // R4
      PDLD_CP_NORMAL: stateNext.pump = '{upNow & ~compare, downNow & ~compare, 1'b0,
                                         stateNext.pump.currentSel};
      PDLD_CP_HIGHZ:  stateNext.pump = '{1'b0, 1'b0, 1'b1, stateNext.pump.currentSel};
      PDLD_CP_UP:     stateNext.pump = '{1'b1, 1'b0, 1'b0, stateNext.pump.currentSel};
      PDLD_CP_DOWN:   stateNext.pump = '{1'b0, 1'b1, 1'b0, stateNext.pump.currentSel};
    endcase

    // ========================================================
    // Calibration sequencer
    stateNext.calArmPrev = stateReg.regs.lockCal[`PDLD_CALEN_BIT];
    calDivisor = 5'h02 << stateReg.regs.lockCal[`PDLD_CALDIV_LSB +: 2]; // R9
    unique case (stateReg.calState)
      PDLD_CAL_IDLE: begin
        if (stateReg.regs.lockCal[`PDLD_CALEN_BIT] && !stateReg.calArmPrev) begin
          stateNext.calState = PDLD_CAL_RUN;
          stateNext.calDiv   = '0;
          stateNext.calCount = '0;
        end
      end
      PDLD_CAL_RUN: begin
        if (!stateReg.regs.lockCal[`PDLD_CALEN_BIT]) begin
          stateNext.calState = PDLD_CAL_IDLE;
        end else if (refPulse) begin
          if ({1'b0, stateReg.calDiv} == calDivisor - 5'h01) begin
            stateNext.calDiv = '0; // R9
            if (stateReg.calCount == CAL_LAST) begin
              stateNext.calState = PDLD_CAL_DONE; // R8
            end else begin
              stateNext.calCount = stateReg.calCount + 13'h0001;
            end
          end else begin
            stateNext.calDiv = stateReg.calDiv + 4'h1;
          end
        end
      end
      PDLD_CAL_DONE: begin
        // Clearing the start bit re-arms; a new 0 to 1 write recalibrates
        if (!stateReg.regs.lockCal[`PDLD_CALEN_BIT]) begin
          stateNext.calState = PDLD_CAL_IDLE;
        end
      end
      default: stateNext.calState = PDLD_CAL_IDLE;
    endcase
    stateNext.outputsHold = (stateNext.calState == PDLD_CAL_RUN); // R7

    // ========================================================
    // Lock, status and watch pins
    cmpOut = stateReg.regs.lockCmp[`PDLD_CMPEN_BIT] & stateReg.sync.cmpS[1]; // R21
    aldRaw = upNow | downNow;
    stateNext.ldOut       = 1'b0;
    stateNext.ldOeN       = 1'b0;
    stateNext.ldSource    = 1'b0;
    stateNext.ldDischarge = 1'b0;
    unique case (ldFn)
      `PDLD_LDFN_DLD: begin
        stateNext.ldOut = stateNext.digitalLockFlag; // R20
      end
      `PDLD_LDFN_ALD_LOW: begin
        stateNext.ldOut = 1'b1; // R22
        stateNext.ldOeN = ~aldRaw;
      end
      `PDLD_LDFN_ALD_HIGH: begin
        stateNext.ldOut = 1'b0; // R22
        stateNext.ldOeN = ~aldRaw;
      end
      `PDLD_LDFN_CLD: begin
        // Pin is a current source here, so the digital driver stays off
        stateNext.ldOeN       = 1'b1;
        stateNext.ldSource    = stateNext.digitalLockFlag; // R21
        stateNext.ldDischarge = ~stateNext.digitalLockFlag; // R21
      end
      default: stateNext.ldOeN = 1'b1;
    endcase
    stateNext.statusPin = (statSel == `PDLD_SEL_DLD) ? stateNext.digitalLockFlag : // R20
                          (statSel == `PDLD_SEL_CMP) ? cmpOut : 1'b0; // R21
    stateNext.watchPin  = (monSel == `PDLD_SEL_DLD) ? stateNext.digitalLockFlag : // R20
                          (monSel == `PDLD_SEL_CMP) ? cmpOut : 1'b0; // R21

    // ========================================================
    // Register access; writes take effect at once
    if (regWrEn) begin
      unique case (regAddr)
        `PDLD_OFS_PUMP:     stateNext.regs.pumpLoop   = regWrData;
        `PDLD_OFS_RDIV_LO:  stateNext.regs.refDivLo   = regWrData;
        `PDLD_OFS_RDIV_HI:  stateNext.regs.refDivHi   = regWrData;
        `PDLD_OFS_SWALLOW:  stateNext.regs.swallowCnt = regWrData;
        `PDLD_OFS_MAIN_LO:  stateNext.regs.mainCntLo  = regWrData;
        `PDLD_OFS_MAIN_HI:  stateNext.regs.mainCntHi  = regWrData;
        `PDLD_OFS_PRES_RST: stateNext.regs.presReset  = regWrData;
        `PDLD_OFS_STAT_SEL: stateNext.regs.statusSel  = regWrData;
        `PDLD_OFS_LOCK_CAL: stateNext.regs.lockCal    = regWrData;
        `PDLD_OFS_SYNC_RST: stateNext.regs.syncRst    = regWrData;
        `PDLD_OFS_LDPIN_FN: stateNext.regs.lockPinFn  = regWrData;
        `PDLD_OFS_MON_SEL:  stateNext.regs.monitorSel = regWrData;
        `PDLD_OFS_LOCK_CMP: stateNext.regs.lockCmp    = regWrData;
        default: ;
      endcase
    end
    if (regRdEn) begin
      unique case (regAddr)
        `PDLD_OFS_PUMP:     stateNext.rdData = stateReg.regs.pumpLoop;
        `PDLD_OFS_RDIV_LO:  stateNext.rdData = stateReg.regs.refDivLo;
        `PDLD_OFS_RDIV_HI:  stateNext.rdData = stateReg.regs.refDivHi;
        `PDLD_OFS_SWALLOW:  stateNext.rdData = stateReg.regs.swallowCnt;
        `PDLD_OFS_MAIN_LO:  stateNext.rdData = stateReg.regs.mainCntLo;
        `PDLD_OFS_MAIN_HI:  stateNext.rdData = stateReg.regs.mainCntHi;
        `PDLD_OFS_PRES_RST: stateNext.rdData = stateReg.regs.presReset;
        `PDLD_OFS_STAT_SEL: stateNext.rdData = stateReg.regs.statusSel;
        `PDLD_OFS_LOCK_CAL: stateNext.rdData = stateReg.regs.lockCal;
        `PDLD_OFS_SYNC_RST: stateNext.rdData = stateReg.regs.syncRst;
        `PDLD_OFS_LDPIN_FN: stateNext.rdData = stateReg.regs.lockPinFn;
        `PDLD_OFS_MON_SEL:  stateNext.rdData = stateReg.regs.monitorSel;
        `PDLD_OFS_LOCK_CMP: stateNext.rdData = stateReg.regs.lockCmp;
        `PDLD_OFS_READBACK: begin
          stateNext.rdData = '0;
          stateNext.rdData[`PDLD_RB_DLD_BIT] = stateReg.digitalLockFlag;
          stateNext.rdData[`PDLD_RB_CAL_BIT] = (stateReg.calState == PDLD_CAL_DONE); // R10
        end
        default: stateNext.rdData = '0;
      endcase
    end
  end

  // ========================================================
  // State register; sync stages reset to idle pin levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stateReg                  <= '0;
      stateReg.sync.syncS       <= 2'b11;
      stateReg.sync.syncPrev    <= 1'b1;
      stateReg.sync.resetS      <= 2'b11;
      stateReg.ldOeN            <= 1'b0;
      stateReg.calState         <= PDLD_CAL_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign regRdData             = stateReg.rdData;
  assign chargePumpUp          = stateReg.pump.up;
  assign chargePumpDown        = stateReg.pump.down;
  assign chargePumpHighZ       = stateReg.pump.highZ;
  assign chargePumpCurrent     = stateReg.pump.currentSel;
  assign lockIndicatorPinOut   = stateReg.ldOut;
  assign lockIndicatorPinOeN   = stateReg.ldOeN;
  assign chargedLockIndication = stateReg.ldSource;
  assign lockPinDischarge      = stateReg.ldDischarge;
  assign statusPin             = stateReg.statusPin;
  assign referenceWatchPin     = stateReg.watchPin;
  assign outputsHold           = stateReg.outputsHold;

endmodule

//--- pdld_pll_ctrl_monitor.sv
`include "pdld_cfg.svh"

module pdld_pll_ctrl_monitor
  import pdld_pkg::*;
#(
  parameter int CAL_CLOCKS = `PDLD_CAL_CLOCKS
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [9:0] regAddr,
  input wire logic       regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       chargePumpUp,
  input wire logic       chargePumpDown,
  input wire logic       chargePumpHighZ,
  input wire logic [2:0] chargePumpCurrent,
  input wire logic       lockIndicatorPinOeN,
  input wire logic       statusPin,
  input wire logic       outputsHold
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Shadow copies of written fields, so outputs can be tied to their cause
  logic [7:0] pumpShadow_reg;
  logic [5:0] ldFnShadow_reg;
  logic       calArm_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pumpShadow_reg <= 8'h00;
      ldFnShadow_reg <= 6'h00;
      calArm_reg     <= 1'b0;
    end else if (regWrEn) begin
      if (regAddr == `PDLD_OFS_PUMP) pumpShadow_reg <= regWrData;
      if (regAddr == `PDLD_OFS_LDPIN_FN) ldFnShadow_reg <= regWrData[5:0];
      if (regAddr == `PDLD_OFS_LOCK_CAL) calArm_reg <= regWrData[0];
    end
  end

  // ==========================================================
  // Assertions
  a_rd_unmapped_zero: assert property (regRdEn && regAddr == 10'h01c |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_data_holds: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data moved without a read");
  a_pump_force_up: assert property (pumpShadow_reg[3:2] == 2'b10 && $stable(pumpShadow_reg)
    |-> chargePumpUp && !chargePumpDown)
    else $error("forced pump up not applied");
  a_pump_force_down: assert property (pumpShadow_reg[3:2] == 2'b11 && $stable(pumpShadow_reg)
    |-> chargePumpDown && !chargePumpUp)
    else $error("forced pump down not applied");
  a_pump_high_imp: assert property (pumpShadow_reg[3:2] == 2'b01 && $stable(pumpShadow_reg)
    |-> chargePumpHighZ)
    else $error("pump not high impedance");
  a_pump_current_step: assert property ($stable(pumpShadow_reg)
    |-> chargePumpCurrent == pumpShadow_reg[6:4])
    else $error("pump current step wrong");
  a_cal_starts_hold: assert property (regWrEn && regAddr == `PDLD_OFS_LOCK_CAL && regWrData[0]
    && !calArm_reg |-> ##[2:3] outputsHold)
    else $error("calibration did not hold outputs");
  a_cal_hold_ends: assert property ($rose(outputsHold) |-> ##[1:1000] !outputsHold)
    else $error("calibration did not finish");
  a_lock_pin_drives: assert property (ldFnShadow_reg == 6'h00 && $stable(ldFnShadow_reg)
    |-> !lockIndicatorPinOeN)
    else $error("lock pin not driven in digital lock mode");

  c_cal_run: cover property ($rose(outputsHold));
  c_pump_up: cover property (chargePumpUp);
  c_locked: cover property ($rose(statusPin));
endmodule

bind pdld_pll_ctrl pdld_pll_ctrl_monitor #(.CAL_CLOCKS(CAL_CLOCKS)) u_mon (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData(regRdData), .chargePumpUp(chargePumpUp),
  .chargePumpDown(chargePumpDown), .chargePumpHighZ(chargePumpHighZ),
  .chargePumpCurrent(chargePumpCurrent), .lockIndicatorPinOeN(lockIndicatorPinOeN),
  .statusPin(statusPin), .outputsHold(outputsHold));

//--- pdld_pll_ctrl_test.sv
`include "pdld_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end

module pdld_pll_ctrl_test
  import pdld_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CC = 4;
  logic        sys_clk, rst, regWrEn, regRdEn, referenceInput, feedbackInput, syncN, resetN;
  logic        lockComparatorIn, up, down, highZ, ldOut, ldOeN, statusPin, hold, cli, dis, wp;
  logic [9:0]  regAddr;
  logic [7:0]  regWrData, regRdData, d, e;
  logic [2:0]  cur;
  logic [1:0]  rdP = 2'b00;
  logic [7:0]  expQ[$];
  logic [31:0] seed;
  int          n_mismatch, checks, n;
  logic [9:0]  ofs[8] = '{10'h011, 10'h012, 10'h013, 10'h014, 10'h015, 10'h017, 10'h01b, 10'h01d};
  // Settings for lock tests: R = 1, P = 1, A = 0, B = 1, lock flag on status pin
  logic [17:0] cfg[9] = '{18'h04000, 18'h04400, 18'h04800, 18'h04c00, 18'h05001, 18'h05400,
                          18'h05800, 18'h05c04, 18'h06800};

  pdld_pll_ctrl #(.CAL_CLOCKS(CC)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .referenceInput(referenceInput),
    .feedbackInput(feedbackInput), .syncN(syncN), .resetN(resetN),
    .lockComparatorIn(lockComparatorIn), .chargePumpUp(up), .chargePumpDown(down),
    .chargePumpHighZ(highZ), .chargePumpCurrent(cur), .lockIndicatorPinOut(ldOut),
    .lockIndicatorPinOeN(ldOeN), .chargedLockIndication(cli), .lockPinDischarge(dis),
    .statusPin(statusPin), .referenceWatchPin(wp), .outputsHold(hold));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = v;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask

  // Idle cycle after each read keeps one answer per outstanding note
  task automatic rd(input logic [9:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    regAddr = a;
    regRdEn = 1'b1;
    expQ.push_back(v);
    @(negedge sys_clk);
    regRdEn = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic pls(input logic f, input int dly);
    @(negedge sys_clk);
    referenceInput = 1'b1;
    repeat (dly) @(negedge sys_clk);
    feedbackInput = f;
    repeat (2) @(negedge sys_clk);
    referenceInput = 1'b0;
    feedbackInput = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic waitv(ref logic s, input logic v);
    for (int i = 0; i < 2000 && s !== v; i++) @(negedge sys_clk);
    `CHK(s, v)
    if (s !== v) stop_test();
  endtask

  // ==========================================================
  // Read answer checker
  always @(posedge sys_clk) rdP <= {rdP[0], regRdEn};
  always @(negedge sys_clk) begin
    if (rdP[1] === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      `CHK(regRdData, e)
    end
  end

  initial begin
    {seed, n_mismatch, checks} = {32'd33, 32'd0, 32'd0};
    {rst, regWrEn, regRdEn, referenceInput, feedbackInput} = 5'b10000;
    {syncN, resetN, lockComparatorIn, regAddr, regWrData} = {3'b110, 10'h000, 8'h00};
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    foreach (ofs[i]) begin
      d = rnd();
      rd(ofs[i], 8'h00);
      wr(ofs[i], d);
      rd(ofs[i], d);
    end
    wr(10'h01c, 8'hff);
    rd(10'h01c, 8'h00);
    wr(`PDLD_OFS_READBACK, 8'hff);
    rd(`PDLD_OFS_READBACK, 8'h00);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      d = rnd();
      wr(`PDLD_OFS_PUMP, {1'b0, d[2:0], m[1:0], 2'b00});
      repeat (3) @(negedge sys_clk);
      `CHK(cur, d[2:0])
      `CHK(up, m == 2)
      `CHK(down, m == 3)
      `CHK(highZ, m == 1)
    end
    wr(`PDLD_OFS_PUMP, 8'h00);
    $display("test pump done");
    foreach (cfg[i]) wr({2'b00, cfg[i][17:10]}, cfg[i][7:0]);
    repeat (3) pls(1'b1, 0);
    `CHK(statusPin, 1'b0)
    repeat (10) pls(1'b1, 0);
    waitv(statusPin, 1'b1);
    `CHK(ldOut, 1'b1)
    `CHK(ldOeN, 1'b0)
    rd(`PDLD_OFS_READBACK, 8'h01);
    wr(`PDLD_OFS_LDPIN_FN, 8'h04);
    wr(`PDLD_OFS_MON_SEL, 8'h01);
    @(negedge sys_clk);
    `CHK({cli, dis, ldOeN, wp}, 4'b1011)
    pls(1'b1, 2);
    waitv(statusPin, 1'b0);
    `CHK({cli, dis, wp}, 3'b010)
    $display("test lock done");
    // Calibration length scales with the divider code; reference pulses only
    for (int k = 0; k < 4; k++) begin
      wr(`PDLD_OFS_LOCK_CAL, 8'h00);
      wr(`PDLD_OFS_LOCK_CAL, 8'(k * 2 + 1));
      repeat (3) @(negedge sys_clk);
      `CHK(hold, 1'b1)
      n = 0;
      while (hold === 1'b1 && n < 300) begin
        pls(1'b0, 0);
        n++;
      end
      `CHK(n >= (2 << k) * CC - 1 && n <= (2 << k) * CC + 2, 1'b1)
      if (hold === 1'b1) stop_test();
      rd(`PDLD_OFS_READBACK, 8'h40);
    end
    // Reference-only pulses leave the up request pending
    wr(`PDLD_OFS_LDPIN_FN, 8'h02);
    @(negedge sys_clk);
    `CHK({ldOut, ldOeN}, 2'b00)
    $display("test calibration done");
    stop_test();
  end
endmodule
